// ### hw/touch_slider_spi_command_port.sv
// serial command port of a capacitive touch slider: framing, commands, sleep and burst sequencing
// assumes the host drives select, clock and data from its own clock domain; acquisition is external
// Operation
// RULE1: clock idles high; shift out on falling edges, sample on rising edges.
// RULE2: eight bits per frame, most significant first, host clock 5 to 40 kHz.
// RULE3: host holds select low for the whole byte, one select per device.
// RULE4: full duplex; outgoing byte reflects the previous command or action.
// RULE5: host raises select at least 35 us after the last clock edge.
// RULE6: within 35 us after last rising edge, sleep and drop go-ahead line.
// RULE7: select rising after a full command byte starts a burst within 1 ms.
// RULE8: select rising while leaving sleep starts a burst about 920 us later.
// RULE9: select held high runs free bursts at about 17 Hz.
// RULE10: unclocked select low pulse triggers one burst; go-ahead drops within 56 us.
// RULE11: burst completion raises the go-ahead line.
// RULE12: data clocked while go-ahead is low is ignored.
// RULE13: power-up: float 20 ms, low 525 ms calibrating, then high.
// RULE14: select low past about 1 s makes the device wake and recalibrate.
// RULE15: on leaving sleep the select pin is pulled low 250 ns.
// RULE16: go-ahead, touch and proximity outputs float 400 us after each wake.
// RULE17: every command returns the same standard response byte.
// RULE18: no touch: bit 7 clear, bit 1 polarity error, bit 0 proximity.
// RULE19: touch: bit 7 set, low seven bits hold position from prior burst.
// RULE20: command 0x00 only shifts response and allows a burst on select rise.
// RULE21: 0x01 runs 10 bursts with go-ahead low and cancels end calibration.
// RULE22: 0x02 runs 20 bursts with go-ahead low to relocate end points.
// RULE23: 0x03 bursts and steps drift once per ten, ignored while touched.
// RULE24: top bits 01 load proximity threshold and burst; default 10.
// RULE25: top bits 10 load touch threshold times four and burst; default 10.
// RULE26: serial data output released after each shift operation.
// RULE27: other 00 codes and all 11 codes act as the null command.
`timescale 1ns/10ps
`default_nettype none
module touch_slider_spi_command_port #(
   parameter int unsigned CAL_PWR_CYCLES = slider_port_pkg::CAL_PWR_CYC,
   parameter int unsigned FLOAT_PWR_CYCLES = slider_port_pkg::FLOAT_PWR_CYC,
   parameter int unsigned SEL_LOW_MAX_CYCLES = slider_port_pkg::SEL_LOW_MAX_CYC,
   parameter int unsigned FREE_RUN_CYCLES = slider_port_pkg::FREE_RUN_CYC,
   parameter int unsigned WAKE_BURST_CYCLES = slider_port_pkg::WAKE_BURST_CYC,
   parameter int unsigned PULSE_BURST_CYCLES = slider_port_pkg::PULSE_BURST_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic sclk,
   input wire logic sel_n_in,
   output logic sel_n_out,
   output logic sel_n_oe,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   output logic host_go_ahead_line,
   output logic host_go_ahead_oe,
   output logic outputs_float,
   output logic sleeping,
   output logic burst_start,
   input wire logic burst_done,
   input wire logic touch_detected,
   input wire logic prox_detected,
   input wire logic polarity_error,
   input wire logic [6:0] position,
   output logic [5:0] prox_threshold,
   output logic [7:0] touch_threshold,
   output logic end_cal_enabled,
   output logic calibrating,
   output logic drift_step
);
   import slider_port_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [1:0] sclk_sync;
   logic [1:0] sel_sync;
   logic [1:0] mosi_sync;
   logic sclk_d;
   logic sel_d;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sclk_sync <= 2'h3;
         sel_sync <= 2'h3;
         mosi_sync <= 2'h0;
         sclk_d <= 1'b1;
         sel_d <= 1'b1;
      end else begin
         sclk_sync <= {sclk_sync[0], sclk};
         sel_sync <= {sel_sync[0], sel_n_in};
         mosi_sync <= {mosi_sync[0], mosi};
         sclk_d <= sclk_sync[1];
         sel_d <= sel_sync[1];
      end
   end
   logic sclk_rise;
   logic sclk_fall;
   logic sel_rise;
   logic sel_fall;
   logic sel_low;
   assign sclk_rise = sclk_sync[1] & ~sclk_d;
   assign sclk_fall = ~sclk_sync[1] & sclk_d;
   assign sel_rise = sel_sync[1] & ~sel_d;
   assign sel_fall = ~sel_sync[1] & sel_d;
   assign sel_low = ~sel_sync[1];

   ////////////////////////////////////////////////////////////////////////
   // command decode helper
   function automatic logic is_burst_cmd(input logic [7:0] c);
      is_burst_cmd = (c != CMD_CAL) && (c != CMD_END_CAL);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state and counters
   port_state_t state;
   logic [31:0] timer;
   logic [2:0] bit_cnt;
   logic [7:0] rx_shift;
   logic [7:0] tx_shift;
   logic byte_done;
   logic clocked;
   logic from_sleep;
   logic [4:0] multi_left;
   logic [3:0] drift_cnt;
   logic [7:0] cmd;
   logic [7:0] response;

   // standard response composed from detection state [RULE17]
   always_comb begin
      if (touch_detected) begin
         response = {1'b1, position}; // [RULE19]
      end else begin
         response = 8'h00; // [RULE18]
         response[RESP_POL_BIT] = polarity_error;
         response[RESP_PROX_BIT] = prox_detected;
      end
   end

   // main sequencer
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= ST_PWR_FLOAT;
         timer <= 32'h0;
         bit_cnt <= 3'h0;
         rx_shift <= 8'h00;
         tx_shift <= 8'h00;
         byte_done <= 1'b0;
         clocked <= 1'b0;
         from_sleep <= 1'b0;
         multi_left <= 5'h00;
         cmd <= 8'h00;
         burst_start <= 1'b0;
         calibrating <= 1'b0;
      end else begin
         burst_start <= 1'b0;
         timer <= timer + 32'h1;
         unique case (state)
            ST_PWR_FLOAT: begin
               if (timer >= FLOAT_PWR_CYCLES - 1) begin // [RULE13]
                  state <= ST_PWR_CAL;
                  timer <= 32'h0;
                  calibrating <= 1'b1;
               end
            end
            ST_PWR_CAL: begin
               if (timer >= CAL_PWR_CYCLES - 1) begin // [RULE13]
                  state <= ST_IDLE;
                  timer <= 32'h0;
                  calibrating <= 1'b0;
               end
            end
            ST_IDLE: begin
               if (sel_fall) begin // [RULE3]
                  state <= ST_SHIFT;
                  timer <= 32'h0;
                  bit_cnt <= 3'h0;
                  clocked <= 1'b0;
                  byte_done <= 1'b0;
                  tx_shift <= response; // [RULE4]
               end else if (timer >= FREE_RUN_CYCLES - 1) begin // [RULE9]
                  state <= ST_BURST;
                  burst_start <= 1'b1;
                  timer <= 32'h0;
               end
            end
            ST_SHIFT: begin
               if (sclk_fall && bit_cnt != 3'h0) begin
                  tx_shift <= {tx_shift[6:0], 1'b0}; // [RULE1]
               end
               if (sclk_rise && !byte_done) begin // [RULE1] [RULE2]
                  rx_shift <= {rx_shift[6:0], mosi_sync[1]};
                  bit_cnt <= bit_cnt + 3'h1;
                  clocked <= 1'b1;
                  timer <= 32'h0;
                  if (bit_cnt == 3'h7) begin
                     byte_done <= 1'b1;
                     cmd <= {rx_shift[6:0], mosi_sync[1]};
                  end
               end
               if (byte_done && timer >= SLEEP_DELAY_CYC - 1) begin // [RULE6]
                  state <= ST_SLEEP;
                  timer <= 32'h0;
               end else if (sel_rise) begin
                  // unclocked pulse forces one burst; partial bytes are dropped
                  state <= ST_WAIT;
                  timer <= 32'h0;
                  from_sleep <= 1'b0;
                  cmd <= clocked ? CMD_NULL : CMD_NULL; // [RULE10]
               end
            end
            ST_SLEEP: begin
               if (sel_rise) begin // [RULE7]
                  state <= ST_WAIT;
                  timer <= 32'h0;
                  from_sleep <= 1'b1;
                  if (cmd == CMD_CAL) begin
                     multi_left <= CAL_BURSTS; // [RULE21]
                  end else if (cmd == CMD_END_CAL) begin
                     multi_left <= END_CAL_BURSTS; // [RULE22]
                  end else begin
                     multi_left <= 5'h00; // [RULE20] [RULE27]
                  end
               end else if (timer >= SEL_LOW_MAX_CYCLES - 1) begin // [RULE14]
                  state <= ST_WAIT;
                  timer <= 32'h0;
                  from_sleep <= 1'b1;
                  multi_left <= CAL_BURSTS;
                  cmd <= CMD_CAL;
               end
            end
            ST_WAIT: begin
               if (timer >= (from_sleep ? WAKE_BURST_CYCLES : PULSE_BURST_CYCLES) - 1) begin // [RULE8] [RULE10]
                  state <= ST_BURST;
                  burst_start <= 1'b1;
                  timer <= 32'h0;
                  calibrating <= !is_burst_cmd(cmd) && from_sleep;
               end
            end
            ST_BURST: begin
               if (burst_done) begin
                  timer <= 32'h0;
                  if (multi_left > 5'h01) begin // [RULE21] [RULE22]
                     multi_left <= multi_left - 5'h01;
                     burst_start <= 1'b1;
                  end else begin
                     multi_left <= 5'h00;
                     calibrating <= 1'b0;
                     cmd <= CMD_NULL;
                     state <= ST_IDLE; // [RULE11]
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration loaded when select rises in sleep after a clocked byte
   logic load_cmd;
   assign load_cmd = (state == ST_SLEEP) && sel_rise;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prox_threshold <= THRESH_DEFAULT;
         touch_threshold <= 8'(THRESH_DEFAULT) << TOUCH_SCALE_SHIFT;
         end_cal_enabled <= 1'b0;
         drift_cnt <= 4'h0;
         drift_step <= 1'b0;
      end else begin
         drift_step <= 1'b0;
         if (load_cmd) begin
            if (cmd[7:6] == CMD_TOP_PROX) begin
               prox_threshold <= cmd[5:0]; // [RULE24]
            end
            if (cmd[7:6] == CMD_TOP_TOUCH) begin
               touch_threshold <= {cmd[5:0], 2'h0}; // [RULE25]
            end
            if (cmd == CMD_CAL) begin
               end_cal_enabled <= 1'b0; // [RULE21]
            end
            if (cmd == CMD_END_CAL) begin
               end_cal_enabled <= 1'b1; // [RULE22]
            end
            if (cmd == CMD_DRIFT && !touch_detected) begin // [RULE23]
               if (drift_cnt == DRIFT_PER_STEP - 4'h1) begin
                  drift_cnt <= 4'h0;
                  drift_step <= 1'b1;
               end else begin
                  drift_cnt <= drift_cnt + 4'h1;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wake diagnostic pulse and output float window
   logic [7:0] diag_cnt;
   logic [31:0] float_cnt;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         diag_cnt <= 8'h00;
         float_cnt <= 32'h0;
      end else begin
         if (state == ST_SLEEP && state != ST_WAIT && (sel_rise || timer >= SEL_LOW_MAX_CYCLES - 1)) begin
            diag_cnt <= 8'(DIAG_CYC); // [RULE15]
            float_cnt <= 32'(FLOAT_WAKE_CYC); // [RULE16]
         end else begin
            if (diag_cnt != 8'h00) diag_cnt <= diag_cnt - 8'h01;
            if (float_cnt != 32'h0) float_cnt <= float_cnt - 32'h1;
         end
      end
   end
   assign sel_n_out = 1'b0;
   assign sel_n_oe = (diag_cnt != 8'h00); // [RULE15]
   assign outputs_float = (float_cnt != 32'h0) || (state == ST_PWR_FLOAT); // [RULE16]
   assign sleeping = (state == ST_SLEEP); // [RULE6]

   // go-ahead high while idle or shifting; it drops with sleep and stays low until the last triggered burst ends [RULE12]
   assign host_go_ahead_line = (state == ST_IDLE) || (state == ST_SHIFT); // [RULE6]
   assign host_go_ahead_oe = !outputs_float;
   // data driven only while a byte is in progress [RULE26]
   assign miso = tx_shift[7];
   assign miso_oe = (state == ST_SHIFT) && !byte_done && sel_low;

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_SLEEP_AFTER_BYTE: assert property (@(posedge clk_sys) disable iff (reset)
      (state == ST_SHIFT && byte_done && $rose(byte_done)) |-> ##[1:700] (state != ST_SHIFT)) else $error("no sleep after byte"); // [RULE6]
   AST_READY_LOW_SLEEP: assert property (@(posedge clk_sys) disable iff (reset)
      sleeping |-> !host_go_ahead_line) else $error("go-ahead high in sleep"); // [RULE6]
   AST_WAKE_BURST: assert property (@(posedge clk_sys) disable iff (reset)
      (state == ST_SLEEP && sel_rise) |=> (state == ST_WAIT) && from_sleep) else $error("no wake after select rise"); // [RULE7]
   AST_PULSE_READY: assert property (@(posedge clk_sys) disable iff (reset)
      (state == ST_SHIFT && sel_rise && !byte_done) |-> ##[1:2] !host_go_ahead_line) else $error("go-ahead not low"); // [RULE10]
   AST_DONE_READY: assert property (@(posedge clk_sys) disable iff (reset)
      (state == ST_BURST && burst_done && multi_left <= 5'h01) |=> host_go_ahead_line) else $error("go-ahead not raised"); // [RULE11]
   AST_CAL_COUNT: assert property (@(posedge clk_sys) disable iff (reset)
      (load_cmd && cmd == CMD_CAL) |=> (multi_left == CAL_BURSTS) && !end_cal_enabled) else $error("calibrate setup wrong"); // [RULE21]
   AST_ENDCAL_COUNT: assert property (@(posedge clk_sys) disable iff (reset)
      (load_cmd && cmd == CMD_END_CAL) |=> (multi_left == END_CAL_BURSTS)) else $error("end calibrate setup wrong"); // [RULE22]
   AST_PROX_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
      (load_cmd && cmd[7:6] == CMD_TOP_PROX) |=> prox_threshold == $past(cmd[5:0])) else $error("prox threshold"); // [RULE24]
   AST_TOUCH_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
      (load_cmd && cmd[7:6] == CMD_TOP_TOUCH) |=> touch_threshold == {$past(cmd[5:0]), 2'h0}) else $error("touch threshold"); // [RULE25]
   AST_MISO_RELEASE: assert property (@(posedge clk_sys) disable iff (reset)
      (state != ST_SHIFT) |-> !miso_oe) else $error("data output not released"); // [RULE26]
endmodule
`default_nettype wire

// ### pkg/slider_port_pkg.sv
// constants and types for the touch-slider serial command port
// assumes a 20 MHz system clock; long counts are overridable at the top level
package slider_port_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned FRAME_BITS = 8;
   // timing figures in their own units
   localparam int unsigned SLEEP_DELAY_US = 35;
   localparam int unsigned WAKE_BURST_US = 920;
   localparam int unsigned PULSE_BURST_US = 1000;
   localparam int unsigned GO_LOW_US = 56;
   localparam int unsigned FLOAT_WAKE_US = 400;
   localparam int unsigned FLOAT_PWR_MS = 20;
   localparam int unsigned CAL_PWR_MS = 525;
   localparam int unsigned SEL_LOW_MAX_MS = 1000;
   localparam int unsigned FREE_RUN_HZ = 17;
   localparam int unsigned DIAG_PULSE_NS = 250;
   // derived cycle counts (longest times round down, least times round up)
   localparam int unsigned SLEEP_DELAY_CYC = SLEEP_DELAY_US * (CLK_HZ / 1000000);
   localparam int unsigned GO_LOW_CYC = 2;
   localparam int unsigned DIAG_CYC = (DIAG_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned WAKE_BURST_CYC = WAKE_BURST_US * (CLK_HZ / 1000000);
   localparam int unsigned PULSE_BURST_CYC = PULSE_BURST_US * (CLK_HZ / 1000000);
   localparam int unsigned FLOAT_WAKE_CYC = FLOAT_WAKE_US * (CLK_HZ / 1000000);
   localparam int unsigned FLOAT_PWR_CYC = FLOAT_PWR_MS * (CLK_HZ / 1000);
   localparam int unsigned CAL_PWR_CYC = CAL_PWR_MS * (CLK_HZ / 1000);
   localparam int unsigned SEL_LOW_MAX_CYC = SEL_LOW_MAX_MS * (CLK_HZ / 1000);
   localparam int unsigned FREE_RUN_CYC = CLK_HZ / FREE_RUN_HZ;
   // commands and burst counts
   localparam logic [7:0] CMD_NULL = 8'h00;
   localparam logic [7:0] CMD_CAL = 8'h01;
   localparam logic [7:0] CMD_END_CAL = 8'h02;
   localparam logic [7:0] CMD_DRIFT = 8'h03;
   localparam logic [1:0] CMD_TOP_PROX = 2'h1;
   localparam logic [1:0] CMD_TOP_TOUCH = 2'h2;
   localparam logic [4:0] CAL_BURSTS = 5'h0a;
   localparam logic [4:0] END_CAL_BURSTS = 5'h14;
   localparam logic [3:0] DRIFT_PER_STEP = 4'ha;
   localparam logic [5:0] THRESH_DEFAULT = 6'h0a;
   localparam int unsigned TOUCH_SCALE_SHIFT = 2;
   // response byte layout
   localparam int unsigned RESP_TOUCH_BIT = 7;
   localparam int unsigned RESP_POL_BIT = 1;
   localparam int unsigned RESP_PROX_BIT = 0;
   typedef enum logic [6:0] {
      ST_PWR_FLOAT = 7'h01,
      ST_PWR_CAL = 7'h02,
      ST_IDLE = 7'h04,
      ST_SHIFT = 7'h08,
      ST_SLEEP = 7'h10,
      ST_WAIT = 7'h20,
      ST_BURST = 7'h40
   } port_state_t;
endpackage

// ### verification/slider_host_model.sv
// host master model: frames command bytes and dummy select pulses
// assumes the bench resolves the select, go-ahead and data pins and feeds them back
`timescale 1ns/10ps
`default_nettype none
module slider_host_model (
   input wire logic clk_sys,
   input wire logic go_line,
   input wire logic miso_line,
   output logic sclk,
   output logic sel_n,
   output logic mosi,
   output logic rx_valid,
   output logic [7:0] rx_byte
);
   ////////////////////////////////////////////////////////////
   // idle pins: clock parked high, select high
   initial begin
      sclk = 1'b1;
      sel_n = 1'b1;
      mosi = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
   end
   // n clock edges, then the fixed drive skew
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   // one full-duplex byte, msb first; data changes on the falling sclk edge
   task automatic send_byte(input logic [7:0] cmd);
      while (go_line !== 1'b1) step(1);
      sel_n = 1'b0;
      step(8);
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b0;
         mosi = cmd[i];
         step(4);
         sclk = 1'b1;
         step(2);
         rx_byte[i] = miso_line; // read while the bit is settled, before the device drops it
         step(2);
      end
      mosi = ~mosi; // a released line no longer shows the last bit
      rx_valid = 1'b1;
      step(1);
      rx_valid = 1'b0;
   endtask
   // keep select low a while after the byte, then raise it
   task automatic end_frame(input int hold);
      step(hold);
      sel_n = 1'b1;
   endtask
   // select low pulse with no clocking
   task automatic dummy_pulse();
      while (go_line !== 1'b1) step(1);
      sel_n = 1'b0;
      step(300); // 15 us low
      sel_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// ### verification/touch_slider_spi_command_port_test.sv
// self-checking bench for the touch-slider serial command port
// assumes the port package and the host model are compiled before this file
`timescale 1ns/10ps
`default_nettype none
module touch_slider_spi_command_port_test;
   import slider_port_pkg::*;
   localparam int unsigned CAL_P = 200;
   localparam int unsigned FLOAT_P = 100;
   localparam int unsigned FREE_P = 3000;
   localparam int unsigned WAKE_P = 300;
   localparam int unsigned PULSE_P = 300;
   logic clk_sys, reset, burst_done, touch_detected, prox_detected, polarity_error, cal_seen;
   logic sel_n_out, sel_n_oe, miso, miso_oe, host_go_ahead_line, host_go_ahead_oe, outputs_float;
   logic sleeping, burst_start, end_cal_enabled, calibrating, drift_step;
   logic [6:0] position;
   logic [5:0] prox_threshold;
   logic [7:0] touch_threshold;
   wire logic sclk, host_sel_n, mosi, rx_valid;
   wire logic [7:0] rx_byte;
   logic [7:0] exp_q[$];
   logic [31:0] rng = 32'h000094ba;
   int mismatches = 0, num_checks = 0, bursts = 0, float_cyc = 0, diag_cyc = 0, drifts = 0, cycles = 0;
   time first_burst = 0;
   ////////////////////////////////////////////////////////////
   // board wiring: device pulls select low, go-ahead has a pull-down
   wire logic sel_line = (sel_n_oe & ~sel_n_out) ? 1'b0 : host_sel_n;
   wire logic go_line = host_go_ahead_oe ? host_go_ahead_line : 1'b0;
   wire logic miso_line = miso_oe ? miso : 1'bz;
   // select never stays low near the sleep timeout here, so that limit keeps its real value
   touch_slider_spi_command_port #(.CAL_PWR_CYCLES(CAL_P), .FLOAT_PWR_CYCLES(FLOAT_P),
      .FREE_RUN_CYCLES(FREE_P), .WAKE_BURST_CYCLES(WAKE_P), .PULSE_BURST_CYCLES(PULSE_P)) dut (
      .clk_sys(clk_sys), .reset(reset), .sclk(sclk), .sel_n_in(sel_line), .sel_n_out(sel_n_out),
      .sel_n_oe(sel_n_oe), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .host_go_ahead_line(host_go_ahead_line),
      .host_go_ahead_oe(host_go_ahead_oe), .outputs_float(outputs_float), .sleeping(sleeping),
      .burst_start(burst_start), .burst_done(burst_done), .touch_detected(touch_detected),
      .prox_detected(prox_detected), .polarity_error(polarity_error), .position(position),
      .prox_threshold(prox_threshold), .touch_threshold(touch_threshold), .end_cal_enabled(end_cal_enabled),
      .calibrating(calibrating), .drift_step(drift_step));
   slider_host_model host (.clk_sys(clk_sys), .go_line(go_line), .miso_line(miso_line), .sclk(sclk),
      .sel_n(host_sel_n), .mosi(mosi), .rx_valid(rx_valid), .rx_byte(rx_byte));
   // 20 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////
   // helpers: random source, expected response, compares, verdict
   function automatic logic [31:0] next_rand();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   function automatic logic [7:0] std_response();
      if (touch_detected) return {1'b1, position};
      return {6'h00, polarity_error, prox_detected};
   endfunction
   task automatic compare_byte(input logic [7:0] got, input logic [7:0] want);
      num_checks++;
      if (got !== want) begin
         mismatches++;
         $display("unexpected response at %0t: got %h, expected %h", $time, got, want);
      end
   endtask
   // value must lie in lo..hi; lo equal to hi for an exact match
   task automatic compare_val(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      num_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         mismatches++;
         $display("unexpected value at %0t: got %h, expected %h", $time, got, lo);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic clear_counts();
      bursts = 0;
      float_cyc = 0;
      diag_cyc = 0;
      cal_seen = 1'b0;
   endtask
   // after select rises: bursts, their start time, float and diagnostic lengths
   task automatic after_rise(input int want_n, input int dly, input logic woke, input time t0);
      int n;
      n = 0;
      // the design's own go-ahead drive marks the end of the triggered bursts, before any free-run one
      while (host_go_ahead_line !== 1'b1 && n < 30000) begin
         host.step(1);
         n++;
      end
      compare_val(bursts, want_n, want_n);
      compare_val((first_burst - t0) / 50, dly, dly + 12);
      compare_val(cal_seen, want_n > 1, want_n > 1);
      // the pin itself stays released until the wake float window is over
      while (go_line !== 1'b1 && n < 30000) begin
         host.step(1);
         n++;
      end
      if (woke) begin
         compare_val(float_cyc, FLOAT_WAKE_CYC - 2, FLOAT_WAKE_CYC + 6);
         compare_val(diag_cyc, DIAG_CYC, DIAG_CYC);
      end
   endtask
   // one command byte with its expected response, sleep checks and burst count
   task automatic transact(input logic [7:0] cmd, input int want_n);
      while (go_line !== 1'b1) host.step(1);
      exp_q.push_back(std_response());
      host.send_byte(cmd);
      host.step(740);
      compare_val(sleeping, 1, 1);
      compare_val(go_line, 0, 0);
      compare_val(miso_oe, 0, 0);
      clear_counts();
      host.end_frame(60); // select rises 805 cycles after the last edge
      after_rise(want_n, WAKE_P, 1'b1, $time);
   endtask
   ////////////////////////////////////////////////////////////
   // acquisition stand-in: fresh results and a done pulse a few cycles after each start
   initial begin
      logic [31:0] r;
      forever begin
         @(posedge clk_sys);
         if (burst_start === 1'b1) begin
            if (bursts == 0) first_burst = $time;
            bursts++;
            r = next_rand();
            repeat (3 + r[3:0]) @(posedge clk_sys);
            #2;
            {touch_detected, prox_detected, polarity_error, position} = r[13:4];
            burst_done = 1'b1;
            host.step(1);
            burst_done = 1'b0;
         end
      end
   end
   // watcher: responses against the queue, pin counters, run limit
   always @(posedge clk_sys) begin
      cycles++;
      if (rx_valid === 1'b1) compare_byte(rx_byte, exp_q.pop_front());
      if (outputs_float === 1'b1) float_cyc++;
      if (sel_n_oe === 1'b1) diag_cyc++;
      if (calibrating === 1'b1) cal_seen = 1'b1;
      if (drift_step === 1'b1) drifts++;
      if (cycles == 90000) begin
         mismatches++;
         $display("unexpected timeout at %0t: cycles %h, limit %h", $time, cycles, 90000);
         print_verdict();
      end
   end
   // main sequence
   initial begin
      logic [31:0] r;
      logic [7:0] cmds[8];
      logic [5:0] want_prox;
      logic [7:0] want_touch;
      logic want_end;
      int n;
      r = next_rand();
      {touch_detected, prox_detected, polarity_error, position} = r[9:0];
      reset = 1'b1;
      burst_done = 1'b0;
      repeat (3) @(posedge clk_sys);
      #2;
      reset = 1'b0;
      compare_val(outputs_float, 1, 1);
      compare_val(host_go_ahead_oe, 0, 0);
      n = 0;
      while (go_line !== 1'b1 && n < 2000) begin
         host.step(1);
         n++;
      end
      compare_val(n, FLOAT_P + CAL_P - 2, FLOAT_P + CAL_P + 8);
      compare_val(prox_threshold, 6'h0a, 6'h0a);
      compare_val(touch_threshold, 8'h28, 8'h28);
      $display("power-up test done");
      clear_counts();
      host.dummy_pulse();
      host.step(4);
      compare_val(go_line, 0, 0);
      after_rise(1, PULSE_P, 1'b0, $time - 200);
      $display("dummy pulse test done");
      want_prox = 6'h0a;
      want_touch = 8'h28;
      want_end = 1'b0;
      r = next_rand();
      cmds = '{CMD_NULL, {CMD_TOP_PROX, r[5:0] | 6'h01}, {CMD_TOP_TOUCH, r[11:6] | 6'h01}, CMD_DRIFT,
         CMD_END_CAL, CMD_CAL, 8'hc5, 8'h2a};
      foreach (cmds[k]) begin
         transact(cmds[k], (cmds[k] == CMD_CAL) ? 10 : (cmds[k] == CMD_END_CAL) ? 20 : 1);
         if (cmds[k][7:6] == CMD_TOP_PROX) want_prox = cmds[k][5:0];
         if (cmds[k][7:6] == CMD_TOP_TOUCH) want_touch = {cmds[k][5:0], 2'b00};
         if (cmds[k] == CMD_CAL || cmds[k] == CMD_END_CAL) want_end = (cmds[k] == CMD_END_CAL);
         compare_val(prox_threshold, want_prox, want_prox);
         compare_val(touch_threshold, want_touch, want_touch);
         compare_val(end_cal_enabled, want_end, want_end);
         $display("command %h test done", cmds[k]);
      end
      compare_val(drifts, 0, 0);
      // align to a fresh entry into idle: let a free-run burst finish first
      while (burst_start !== 1'b1) host.step(1);
      while (host_go_ahead_line !== 1'b1) host.step(1);
      clear_counts();
      host.step(FREE_P - 30);
      compare_val(bursts, 0, 0);
      host.step(60);
      compare_val(bursts, 1, 1);
      host.step(30);
      compare_val(go_line, 1, 1);
      $display("free-run test done");
      print_verdict();
   end
endmodule
`default_nettype wire
